// ---- design/timer_ext_pkg.sv ----
// shared constants and types for the counter unit and its scaler
package timer_ext_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int COUNT_W = 8;
    localparam int SCALER_W = 8;
    localparam int RATIO_W = 3;
    localparam int WDT_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // configuration field positions (low four bits)
    localparam int CFG_RATIO_LSB = 0;
    localparam int CFG_SEL_BIT = 3;
    localparam int CFG_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
    localparam logic [SCALER_W-1:0] SCALER_RST = 8'h00;
    localparam logic [WDT_W-1:0] WDT_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // timing: one oscillator period is one core clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TOSC_PS = 4000;
    localparam int EXT_MIN_LEVEL_TOSC = 2;
    localparam int EXT_MIN_PERIOD_TOSC = 4;
    localparam int EXT_MIN_LEVEL_CYC =
        (EXT_MIN_LEVEL_TOSC * TOSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EXT_MIN_PERIOD_CYC =
        (EXT_MIN_PERIOD_TOSC * TOSC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WDT_CYCLES_DEF = 1024;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_t;

    typedef struct packed {
        logic assign_wdt;
        logic [RATIO_W-1:0] ratio;
    } tmr_cfg_t;

    typedef struct packed {
        logic wr;
        logic [COUNT_W-1:0] data;
    } count_wr_t;

    // low n bits set: postscaler terminal count pattern
    function automatic logic [SCALER_W-1:0] ratio_mask(
        input logic [RATIO_W-1:0] n
    );
        return (SCALER_W'(1) << n) - SCALER_W'(1);
    endfunction

endpackage

// ---- design/scaler_counter.sv ----
// eight-bit shared scaling counter with clear priority
`timescale 1ns/1ps
`default_nettype none
module scaler_counter
    import timer_ext_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // control
    input wire logic clear_i,
    input wire logic tick_i,
    // count
    output logic [SCALER_W-1:0] count_o
);

    logic [SCALER_W-1:0] cnt_q;
    logic [SCALER_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (clear_i) begin
            cnt_d = SCALER_RST;
        end else if (tick_i) begin
            cnt_d = cnt_q + SCALER_W'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= SCALER_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count_o = cnt_q;

endmodule // scaler_counter
`default_nettype wire

// ---- design/timer_ext_clock_prescaler.sv ----
// counter unit with external count input, shared scaler and watchdog
`timescale 1ns/1ps
`default_nettype none
// Function
// - scaler given to watchdog: counter path sees the raw count input
// - scaler output sampled on phase two and phase four only
// - scaled mode divides the count input into a symmetrical output
// - counter increments one cycle after the sampled edge is captured
// - one eight-bit scaler serves either counter or watchdog
// - scaler assignment exclusive; the other user runs unscaled
// - select bit three, ratio bits two to zero of configuration
// - counter writes clear the scaler when it serves the counter
// - watchdog clear resets watchdog and scaler when it serves watchdog
// - scaler count has no software read or write path
module timer_ext_clock_prescaler
    import timer_ext_pkg::*;
#(
    parameter int unsigned WDT_CYCLES = WDT_CYCLES_DEF
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // external count pin
    input wire logic ext_count_input_i,
    // configuration, core logic
    input wire tmr_cfg_t cfg_i,
    // core access to the counter
    input wire count_wr_t count_wr_i,
    input wire logic watchdog_clear_instruction_i,
    // status
    output logic [COUNT_W-1:0] count_register_o,
    output logic count_overflow_o,
    output logic watchdog_timeout_o
);

    ////////////////////////////////////////////////////////////////////////
    // configuration decode
    logic [CFG_W-1:0] cfg_bits;
    logic scaler_assign_select;
    logic [RATIO_W-1:0] scale_ratio_select;

    assign cfg_bits = cfg_i;
    assign scaler_assign_select = cfg_bits[CFG_SEL_BIT];
    assign scale_ratio_select = cfg_bits[CFG_RATIO_LSB +: RATIO_W];

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser and edge finder
    logic ext_meta_q;
    logic ext_sync_q;
    logic ext_prev_q;
    logic ext_rise;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_count_input_i;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    assign ext_rise = ext_sync_q & ~ext_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // internal phase clocks, one instruction cycle is four core clocks
    phase_t phase_q;
    phase_t phase_d;

    always_comb begin
        unique case (phase_q)
            PH_ONE: phase_d = PH_TWO;
            PH_TWO: phase_d = PH_THREE;
            PH_THREE: phase_d = PH_FOUR;
            PH_FOUR: phase_d = PH_ONE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= PH_ONE;
        end else begin
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog timer
    logic [WDT_W-1:0] wdt_cnt_q;
    logic [WDT_W-1:0] wdt_cnt_d;
    logic wdt_ovf;

    assign wdt_ovf = (wdt_cnt_q == WDT_W'(WDT_CYCLES - 1));

    always_comb begin
        wdt_cnt_d = wdt_cnt_q + WDT_W'(1);
        if (watchdog_clear_instruction_i || wdt_ovf) begin
            wdt_cnt_d = WDT_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared scaler, owned by one user at a time
    logic [SCALER_W-1:0] scaler_cnt;
    logic scaler_tick;
    logic scaler_clear;
    logic scaler_out;

    always_comb begin
        if (scaler_assign_select) begin
            scaler_tick = wdt_ovf;
            scaler_clear = watchdog_clear_instruction_i;
            scaler_out = ext_sync_q;
        end else begin
            scaler_tick = ext_rise;
            scaler_clear = count_wr_i.wr;
            scaler_out = scaler_cnt[scale_ratio_select];
        end
    end

    // count kept internal, no port exposes it
    scaler_counter u_scaler (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clear_i(scaler_clear),
        .tick_i(scaler_tick),
        .count_o(scaler_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // phase sampling and counter register
    logic samp_q;
    logic samp_d;
    logic samp_prev_q;
    logic samp_prev_d;
    logic fresh_q;
    logic fresh_d;
    logic inc;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic ovf_q;
    logic ovf_d;
    logic wdt_to_q;
    logic wdt_to_d;

    assign inc = fresh_q & samp_q & ~samp_prev_q;

    always_comb begin
        samp_d = samp_q;
        samp_prev_d = samp_prev_q;
        fresh_d = 1'b0;
        if (phase_q == PH_TWO || phase_q == PH_FOUR) begin
            samp_d = scaler_out;
            samp_prev_d = samp_q;
            fresh_d = 1'b1;
        end
        count_d = count_q;
        ovf_d = 1'b0;
        if (count_wr_i.wr) begin
            count_d = count_wr_i.data;
        end else if (inc) begin
            count_d = count_q + COUNT_W'(1);
            ovf_d = (count_q == {COUNT_W{1'b1}});
        end
        if (scaler_assign_select) begin
            wdt_to_d = wdt_ovf &&
                ((scaler_cnt & ratio_mask(scale_ratio_select)) ==
                 ratio_mask(scale_ratio_select));
        end else begin
            wdt_to_d = wdt_ovf;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            samp_q <= 1'b0;
            samp_prev_q <= 1'b0;
            fresh_q <= 1'b0;
            count_q <= COUNT_RST;
            ovf_q <= 1'b0;
            wdt_to_q <= 1'b0;
            wdt_cnt_q <= WDT_RST;
        end else begin
            samp_q <= samp_d;
            samp_prev_q <= samp_prev_d;
            fresh_q <= fresh_d;
            count_q <= count_d;
            ovf_q <= ovf_d;
            wdt_to_q <= wdt_to_d;
            wdt_cnt_q <= wdt_cnt_d;
        end
    end

    assign count_register_o = count_q;
    assign count_overflow_o = ovf_q;
    assign watchdog_timeout_o = wdt_to_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_sampled_rise;
        (phase_q == PH_TWO || phase_q == PH_FOUR) && !samp_q && scaler_out;
    endsequence

    sequence s_no_write;
        !count_wr_i.wr;
    endsequence

    property p_bypass_path;
        @(posedge mclk_i) disable iff (rst_i)
        scaler_assign_select && !$past(rst_i) && !$past(rst_i, 2) |->
            scaler_out == $past(ext_count_input_i, 2);
    endproperty
    a_bypass_path: assert property (p_bypass_path)
        else $error("bypass path does not carry the raw input");

    property p_sample_phase;
        @(posedge mclk_i) disable iff (rst_i)
        $changed(samp_q) |->
            ($past(phase_q) == PH_TWO || $past(phase_q) == PH_FOUR);
    endproperty
    a_sample_phase: assert property (p_sample_phase)
        else $error("sample taken outside phase two or four");

    property p_divide;
        @(posedge mclk_i) disable iff (rst_i)
        !scaler_assign_select && !count_wr_i.wr && ext_rise &&
            (scaler_cnt == {SCALER_W{1'b1}}) |=> (scaler_cnt == SCALER_RST);
    endproperty
    a_divide: assert property (p_divide)
        else $error("scaler did not wrap on full count");

    property p_incr_delay;
        @(posedge mclk_i) disable iff (rst_i)
        s_sampled_rise ##1 s_no_write |=>
            count_q == $past(count_q) + COUNT_W'(1);
    endproperty
    a_incr_delay: assert property (p_incr_delay)
        else $error("counter not incremented after captured edge");

    property p_no_early_incr;
        @(posedge mclk_i) disable iff (rst_i)
        !$past(count_wr_i.wr) && $changed(count_q) |->
            $past(fresh_q) && $past(samp_q) && !$past(samp_prev_q);
    endproperty
    a_no_early_incr: assert property (p_no_early_incr)
        else $error("counter changed without a captured edge");

    property p_exclusive;
        @(posedge mclk_i) disable iff (rst_i)
        !scaler_assign_select && wdt_ovf |=> watchdog_timeout_o;
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("watchdog scaled while scaler serves counter");

    property p_post_hold;
        @(posedge mclk_i) disable iff (rst_i)
        scaler_assign_select &&
            (scaler_cnt & ratio_mask(scale_ratio_select)) !=
            ratio_mask(scale_ratio_select) |=> !watchdog_timeout_o;
    endproperty
    a_post_hold: assert property (p_post_hold)
        else $error("watchdog timeout before the postscale count");

    property p_write_clears;
        @(posedge mclk_i) disable iff (rst_i)
        !scaler_assign_select && count_wr_i.wr |=>
            scaler_cnt == SCALER_RST &&
            count_q == $past(count_wr_i.data);
    endproperty
    a_write_clears: assert property (p_write_clears)
        else $error("counter write did not clear the scaler");

    property p_wdt_clear;
        @(posedge mclk_i) disable iff (rst_i)
        scaler_assign_select && watchdog_clear_instruction_i |=>
            scaler_cnt == SCALER_RST && wdt_cnt_q == WDT_RST;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog clear missed watchdog or scaler");

    property p_ratio;
        @(posedge mclk_i) disable iff (rst_i)
        !scaler_assign_select && !$past(scaler_assign_select) &&
            $stable(scale_ratio_select) && $rose(scaler_out) |->
            (scaler_cnt & ratio_mask(scale_ratio_select)) == SCALER_RST;
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("scaler output is not the selected tap");

    property p_wrap;
        @(posedge mclk_i) disable iff (rst_i)
        inc && !count_wr_i.wr && count_q == {COUNT_W{1'b1}} |=>
            count_q == COUNT_RST ##0 count_overflow_o ##1 !count_overflow_o;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to zero with overflow");

endmodule // timer_ext_clock_prescaler
`default_nettype wire

// ---- verification/ext_clock_source.sv ----
// external count clock source driving the count pin
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
    // core clock
    input wire logic clk_i,
    // count pin
    output logic pin_o
);
    initial pin_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // 64 ns period, 8 core cycles each level, low and still between bursts
    task automatic burst(input int n);
        repeat (n) begin
            pin_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
    endtask
endmodule // ext_clock_source
`default_nettype wire

// ---- verification/timer_ext_clock_prescaler_tb_top.sv ----
// testbench for the counter unit with external count input
`timescale 1ns/1ps
`default_nettype none
module timer_ext_clock_prescaler_tb_top;
    import timer_ext_pkg::*;
    logic mclk_i, rst_i, wdc, ovf, wto;
    tmr_cfg_t cfg;
    count_wr_t cwr;
    wire logic pin;
    logic [COUNT_W-1:0] cnt;
    int n_fail = 0, checks_done = 0, n_ovf = 0, n_to = 0, k;

    ext_clock_source src_u (.clk_i(mclk_i), .pin_o(pin));
    timer_ext_clock_prescaler #(.WDT_CYCLES(16)) dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .ext_count_input_i(pin),
        .cfg_i(cfg), .count_wr_i(cwr),
        .watchdog_clear_instruction_i(wdc),
        .count_register_o(cnt), .count_overflow_o(ovf),
        .watchdog_timeout_o(wto));

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    // pulse counters, sampled away from the launching edge
    always @(negedge mclk_i) begin
        if (ovf === 1'b1) n_ovf++;
        if (wto === 1'b1) n_to++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] exp, input string msg);
        checks_done++;
        if (cnt !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s %h/%h", $time, msg, cnt, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp, input string msg);
        checks_done++;
        if (got != exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s %0d/%0d", $time, msg, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // config with a two-cycle write; the second masks a stale tap edge
    task automatic setup(input logic a, input logic [2:0] r,
            input logic [7:0] d);
        @(posedge mclk_i);
        cfg <= '{assign_wdt: a, ratio: r};
        cwr <= '{wr: 1'b1, data: d};
        cyc(2);
        cwr.wr <= 1'b0;
        cyc(2);
    endtask
    task automatic pulses(input int n);
        src_u.burst(n);
        cyc(10);
    endtask
    task automatic wd_clear;
        @(posedge mclk_i);
        wdc <= 1'b1;
        @(posedge mclk_i);
        wdc <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_bypass;
        setup(1'b1, 3'h7, 8'h20);
        pulses(5);
        chk8(8'h25, "bypass");
        $display("test bypass done");
    endtask
    task automatic t_ratios;
        for (int r = 0; r < 8; r++) begin
            setup(1'b0, r[2:0], 8'h00);
            pulses((1 << r) - 1);
            chk8(8'h00, "ratio lead");
            pulses(1);
            chk8(8'h01, "ratio first");
            pulses((2 << r) - 1);
            chk8(8'h01, "ratio short");
            pulses(1);
            chk8(8'h02, "ratio full");
        end
        $display("test ratios done");
    endtask
    task automatic t_write_clear;
        setup(1'b0, 3'h1, 8'h10);
        pulses(1);
        chk8(8'h10, "no count yet");
        setup(1'b0, 3'h1, 8'h10);
        pulses(1);
        chk8(8'h10, "scaler cleared");
        pulses(1);
        chk8(8'h11, "after clear");
        $display("test write clear done");
    endtask
    task automatic t_wrap;
        setup(1'b1, 3'h0, 8'hff);
        k = n_ovf;
        pulses(1);
        chk8(8'h00, "wrap");
        chkn(n_ovf - k, 1, "overflow");
        $display("test wrap done");
    endtask
    task automatic t_wdt;
        setup(1'b0, 3'h3, 8'h00);
        wd_clear;
        cyc(8);
        k = n_to;
        cyc(160);
        chkn(n_to - k, 10, "wdt unscaled");
        setup(1'b1, 3'h2, 8'h00);
        cyc(100);
        wd_clear;
        cyc(1);
        k = n_to;
        cyc(59);
        chkn(n_to - k, 0, "wdt early");
        cyc(10);
        chkn(n_to - k, 1, "wdt scaled");
        $display("test watchdog done");
    endtask

    initial begin
        #200000;
        n_fail++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        test_done();
    end

    initial begin
        rst_i = 1'b1;
        wdc = 1'b0;
        cfg = '0;
        cwr = '0;
        cyc(5);
        rst_i <= 1'b0;
        cyc(2);
        chk8(COUNT_RST, "reset value");
        t_bypass();
        t_ratios();
        t_write_clear();
        t_wrap();
        t_wdt();
        test_done();
    end
endmodule // timer_ext_clock_prescaler_tb_top
`default_nettype wire
